// ---- pkg/sbt_pkg.sv ----
// constants, types and state codes of the boundary-scan test access port
package sbt_pkg;

    // register widths
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_W = 110;
    localparam int BSR_HIZ_BIT = 109;

    // instruction codes
    localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
    localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
    localparam logic [IR_W-1:0] INS_SAMPLEZ = 3'h2;
    localparam logic [IR_W-1:0] INS_PRELOAD = 3'h4;
    localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;

    // capture pattern of the instruction register, upper bit then the two low bits
    localparam logic IR_CAPT_MSB = 1'h0;
    localparam logic [1:0] IR_CAPT_LSB = 2'h1;

    // identification word, value arbitrary; bit 0 set as the scan protocol demands
    localparam logic [ID_W-1:0] IDCODE_VAL = 32'h0A5C_3001;

    // reset values
    localparam logic [BSR_W-1:0] BSR_UPD_RST = {BSR_W{1'b0}};
    localparam logic BYP_CAPT_VAL = 1'h0;

    // rising edges with mode select high that always reach test-logic-reset
    localparam logic [2:0] TLR_TMS_EDGES = 3'h5;

    // test pins as sampled together
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } sbt_pins_s;

    // open pins read high, a parked clock reads low
    localparam sbt_pins_s PIN_RST_VAL = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};

    // controller states
    typedef enum logic [15:0] {
        ST_TLR    = 16'h0001,
        ST_RTI    = 16'h0002,
        ST_SELDR  = 16'h0004,
        ST_CAPDR  = 16'h0008,
        ST_SHDR   = 16'h0010,
        ST_EX1DR  = 16'h0020,
        ST_PAUSDR = 16'h0040,
        ST_EX2DR  = 16'h0080,
        ST_UPDR   = 16'h0100,
        ST_SELIR  = 16'h0200,
        ST_CAPIR  = 16'h0400,
        ST_SHIR   = 16'h0800,
        ST_EX1IR  = 16'h1000,
        ST_PAUSIR = 16'h2000,
        ST_EX2IR  = 16'h4000,
        ST_UPIR   = 16'h8000
    } sbt_state_e;

    // serial path selection
    typedef enum logic [3:0] {
        SEL_IR  = 4'h1,
        SEL_BYP = 4'h2,
        SEL_ID  = 4'h4,
        SEL_BSR = 4'h8
    } sbt_sel_e;

endpackage

// ---- hdl/sbt_sync.sv ----
// two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
module sbt_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // sbt_sync

// ---- hdl/sbt_tap.sv ----
// boundary-scan test access port, oversampling the test clock with sys_clk
//
// How it works
// - behave as a standard boundary-scan access port within the small instruction set
// - inputs taken at test clock rise, data out and its enable changed only at its fall
// - the current instruction picks the register between data in and data out
// - serial data enters the top bit of the selected register
// - data out shows the lowest bit of the selected register
// - data out driven only in shift states, high impedance otherwise
// - reset state at power-up with no test clock, memory untouched
// - unconnected mode select and data in count as high only at reset, from the synchroniser reset values
// - five rises with mode select high reach test-logic-reset
// - capture-IR loads binary 01 into the two low instruction bits
// - test-logic-reset loads the identification instruction
// - bypass is one bit between data in and out, cleared on capture
`timescale 1ns/10ps
module sbt_tap (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic [sbt_pkg::BSR_W-1:0] ring_in,
    output logic tdo,
    output logic tdo_oe,
    output logic [sbt_pkg::IR_W-1:0] instr,
    output logic [sbt_pkg::BSR_W-1:0] bsr_update,
    output logic out_hiz
);
    sbt_pkg::sbt_pins_s pin_raw;
    sbt_pkg::sbt_pins_s pin_s;
    sbt_pkg::sbt_state_e state_q;
    sbt_pkg::sbt_state_e state_d;
    sbt_pkg::sbt_sel_e cur_sel;
    logic tck_prev_q;
    logic tck_rise;
    logic tck_fall;
    logic [sbt_pkg::IR_W-1:0] ir_q;
    logic [sbt_pkg::IR_W-1:0] ir_sh_q;
    logic byp_q;
    logic [sbt_pkg::ID_W-1:0] id_q;
    logic [sbt_pkg::BSR_W-1:0] bsr_q;
    logic [sbt_pkg::BSR_W-1:0] bsr_upd_q;
    logic tdo_q;
    logic tdo_oe_q;
    logic out_hiz_q;
    logic [2:0] tms_cnt_q;

    // data register picked by an instruction; privates fall back to bypass
    function automatic sbt_pkg::sbt_sel_e dr_sel(input logic [sbt_pkg::IR_W-1:0] ins);
        if (ins == sbt_pkg::INS_IDCODE) begin
            return sbt_pkg::SEL_ID;
        end else if (ins == sbt_pkg::INS_EXTEST || ins == sbt_pkg::INS_SAMPLEZ ||
                     ins == sbt_pkg::INS_PRELOAD) begin
            return sbt_pkg::SEL_BSR;
        end else begin
            return sbt_pkg::SEL_BYP;
        end
    endfunction

    // pins cross into sys_clk; reset values read open pins as high
    assign pin_raw = '{tck: tck, tms: tms, tdi: tdi};
    sbt_sync #(
        .W(3),
        .RST_VAL(sbt_pkg::PIN_RST_VAL)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .d(pin_raw),
        .q(pin_s)
    );

    // edge finder on the synchronised test clock; a parked clock gives none
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tck_prev_q <= 1'b0;
        end else begin
            tck_prev_q <= pin_s.tck;
        end
    end
    assign tck_rise = pin_s.tck & ~tck_prev_q;
    assign tck_fall = ~pin_s.tck & tck_prev_q;

    // standard controller transitions
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            sbt_pkg::ST_TLR: state_d = pin_s.tms ? sbt_pkg::ST_TLR : sbt_pkg::ST_RTI;
            sbt_pkg::ST_RTI: state_d = pin_s.tms ? sbt_pkg::ST_SELDR : sbt_pkg::ST_RTI;
            sbt_pkg::ST_SELDR: state_d = pin_s.tms ? sbt_pkg::ST_SELIR : sbt_pkg::ST_CAPDR;
            sbt_pkg::ST_CAPDR: state_d = pin_s.tms ? sbt_pkg::ST_EX1DR : sbt_pkg::ST_SHDR;
            sbt_pkg::ST_SHDR: state_d = pin_s.tms ? sbt_pkg::ST_EX1DR : sbt_pkg::ST_SHDR;
            sbt_pkg::ST_EX1DR: state_d = pin_s.tms ? sbt_pkg::ST_UPDR : sbt_pkg::ST_PAUSDR;
            sbt_pkg::ST_PAUSDR: state_d = pin_s.tms ? sbt_pkg::ST_EX2DR : sbt_pkg::ST_PAUSDR;
            sbt_pkg::ST_EX2DR: state_d = pin_s.tms ? sbt_pkg::ST_UPDR : sbt_pkg::ST_SHDR;
            sbt_pkg::ST_UPDR: state_d = pin_s.tms ? sbt_pkg::ST_SELDR : sbt_pkg::ST_RTI;
            sbt_pkg::ST_SELIR: state_d = pin_s.tms ? sbt_pkg::ST_TLR : sbt_pkg::ST_CAPIR;
            sbt_pkg::ST_CAPIR: state_d = pin_s.tms ? sbt_pkg::ST_EX1IR : sbt_pkg::ST_SHIR;
            sbt_pkg::ST_SHIR: state_d = pin_s.tms ? sbt_pkg::ST_EX1IR : sbt_pkg::ST_SHIR;
            sbt_pkg::ST_EX1IR: state_d = pin_s.tms ? sbt_pkg::ST_UPIR : sbt_pkg::ST_PAUSIR;
            sbt_pkg::ST_PAUSIR: state_d = pin_s.tms ? sbt_pkg::ST_EX2IR : sbt_pkg::ST_PAUSIR;
            sbt_pkg::ST_EX2IR: state_d = pin_s.tms ? sbt_pkg::ST_UPIR : sbt_pkg::ST_SHIR;
            sbt_pkg::ST_UPIR: state_d = pin_s.tms ? sbt_pkg::ST_SELDR : sbt_pkg::ST_RTI;
            default: state_d = sbt_pkg::ST_TLR; // a corrupted one-hot code recovers
        endcase
    end

    // state steps only at a test clock rise; reset needs no test clock
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= sbt_pkg::ST_TLR;
        end else if (tck_rise) begin
            state_q <= state_d;
        end
    end

    // path between data in and data out
    assign cur_sel = (state_q == sbt_pkg::ST_CAPIR || state_q == sbt_pkg::ST_SHIR ||
                      state_q == sbt_pkg::ST_EX1IR || state_q == sbt_pkg::ST_PAUSIR ||
                      state_q == sbt_pkg::ST_EX2IR) ? sbt_pkg::SEL_IR : dr_sel(ir_q);

    // instruction shift stage: capture pattern, then shift in at the top
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ir_sh_q <= sbt_pkg::INS_IDCODE;
        end else if (tck_rise && state_q == sbt_pkg::ST_CAPIR) begin
            ir_sh_q <= {sbt_pkg::IR_CAPT_MSB, sbt_pkg::IR_CAPT_LSB};
        end else if (tck_rise && state_q == sbt_pkg::ST_SHIR) begin
            ir_sh_q <= {pin_s.tdi, ir_sh_q[sbt_pkg::IR_W-1:1]};
        end
    end

    // held instruction; reset state forces the identification one
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ir_q <= sbt_pkg::INS_IDCODE;
        end else if (state_q == sbt_pkg::ST_TLR) begin
            ir_q <= sbt_pkg::INS_IDCODE;
        end else if (tck_rise && state_q == sbt_pkg::ST_UPIR) begin
            ir_q <= ir_sh_q;
        end
    end

    // one-bit bypass, cleared on capture
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            byp_q <= sbt_pkg::BYP_CAPT_VAL;
        end else if (tck_rise && cur_sel == sbt_pkg::SEL_BYP) begin
            if (state_q == sbt_pkg::ST_CAPDR) begin
                byp_q <= sbt_pkg::BYP_CAPT_VAL;
            end else if (state_q == sbt_pkg::ST_SHDR) begin
                byp_q <= pin_s.tdi;
            end
        end
    end

    // identification register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            id_q <= sbt_pkg::IDCODE_VAL;
        end else if (tck_rise && cur_sel == sbt_pkg::SEL_ID) begin
            if (state_q == sbt_pkg::ST_CAPDR) begin
                id_q <= sbt_pkg::IDCODE_VAL;
            end else if (state_q == sbt_pkg::ST_SHDR) begin
                id_q <= {pin_s.tdi, id_q[sbt_pkg::ID_W-1:1]};
            end
        end
    end

    // boundary register: capture the pin ring, shift from the top
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bsr_q <= sbt_pkg::BSR_UPD_RST;
        end else if (tck_rise && cur_sel == sbt_pkg::SEL_BSR) begin
            if (state_q == sbt_pkg::ST_CAPDR) begin
                bsr_q <= ring_in; // ring is unsynchronised; values mid-transition are undefined
            end else if (state_q == sbt_pkg::ST_SHDR) begin
                bsr_q <= {pin_s.tdi, bsr_q[sbt_pkg::BSR_W-1:1]};
            end
        end
    end

    // preload latch, cleared by the reset state
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bsr_upd_q <= sbt_pkg::BSR_UPD_RST;
        end else if (state_q == sbt_pkg::ST_TLR) begin
            bsr_upd_q <= sbt_pkg::BSR_UPD_RST;
        end else if (tck_rise && state_q == sbt_pkg::ST_UPDR && cur_sel == sbt_pkg::SEL_BSR) begin
            bsr_upd_q <= bsr_q;
        end
    end

    // serial output and its enable move only at the falling edge
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe_q <= (state_q == sbt_pkg::ST_SHDR || state_q == sbt_pkg::ST_SHIR);
            unique case (cur_sel)
                sbt_pkg::SEL_IR: tdo_q <= ir_sh_q[0];
                sbt_pkg::SEL_BYP: tdo_q <= byp_q;
                sbt_pkg::SEL_ID: tdo_q <= id_q[0];
                sbt_pkg::SEL_BSR: tdo_q <= bsr_q[0];
            endcase
        end
    end

    // memory output bus float request, never active outside test instructions
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            out_hiz_q <= 1'b0;
        end else begin
            out_hiz_q <= (ir_q == sbt_pkg::INS_SAMPLEZ) ||
                         (ir_q == sbt_pkg::INS_EXTEST && !bsr_upd_q[sbt_pkg::BSR_HIZ_BIT]);
        end
    end

    assign tdo = tdo_q;
    assign tdo_oe = tdo_oe_q;
    assign instr = ir_q;
    assign bsr_update = bsr_upd_q;
    assign out_hiz = out_hiz_q;

    // helper: consecutive rises with mode select high, saturating
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tms_cnt_q <= 3'h0;
        end else if (tck_rise) begin
            if (!pin_s.tms) begin
                tms_cnt_q <= 3'h0;
            end else if (tms_cnt_q != sbt_pkg::TLR_TMS_EDGES) begin
                tms_cnt_q <= tms_cnt_q + 3'h1;
            end
        end
    end

    property p_five_tms_reset;
        @(posedge sys_clk) disable iff (rst)
        (tck_rise && pin_s.tms && tms_cnt_q == 3'h4) |=> (state_q == sbt_pkg::ST_TLR);
    endproperty
    a_five_tms_reset: assert property (p_five_tms_reset) else $error("five tms highs missed reset");

    property p_tdo_on_fall;
        @(posedge sys_clk) disable iff (rst)
        ($changed(tdo_q) || $changed(tdo_oe_q)) |-> $past(tck_fall);
    endproperty
    a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("tdo moved off a falling edge");

    property p_state_on_rise;
        @(posedge sys_clk) disable iff (rst)
        $changed(state_q) |-> $past(tck_rise);
    endproperty
    a_state_on_rise: assert property (p_state_on_rise) else $error("state moved without tck rise");

    property p_oe_shift_only;
        @(posedge sys_clk) disable iff (rst)
        tck_fall |=> (tdo_oe_q == ($past(state_q) == sbt_pkg::ST_SHDR ||
                                   $past(state_q) == sbt_pkg::ST_SHIR));
    endproperty
    a_oe_shift_only: assert property (p_oe_shift_only) else $error("tdo enable outside shift");

    property p_capir_pattern;
        @(posedge sys_clk) disable iff (rst)
        (tck_rise && state_q == sbt_pkg::ST_CAPIR) |=> (ir_sh_q[1:0] == 2'h1);
    endproperty
    a_capir_pattern: assert property (p_capir_pattern) else $error("capture-IR pattern wrong");

    property p_tlr_idcode;
        @(posedge sys_clk) disable iff (rst)
        (state_q == sbt_pkg::ST_TLR) |=> (ir_q == sbt_pkg::INS_IDCODE);
    endproperty
    a_tlr_idcode: assert property (p_tlr_idcode) else $error("reset state lost idcode");

    property p_bypass_clear;
        @(posedge sys_clk) disable iff (rst)
        (tck_rise && state_q == sbt_pkg::ST_CAPDR && cur_sel == sbt_pkg::SEL_BYP) |=> !byp_q;
    endproperty
    a_bypass_clear: assert property (p_bypass_clear) else $error("bypass not cleared");

    property p_tdi_to_msb;
        @(posedge sys_clk) disable iff (rst)
        (tck_rise && state_q == sbt_pkg::ST_SHDR && cur_sel == sbt_pkg::SEL_BSR)
            |=> (bsr_q[sbt_pkg::BSR_W-1] == $past(pin_s.tdi));
    endproperty
    a_tdi_to_msb: assert property (p_tdi_to_msb) else $error("tdi not in msb");

    property p_lsb_out;
        @(posedge sys_clk) disable iff (rst)
        (tck_fall && state_q == sbt_pkg::ST_SHDR && cur_sel == sbt_pkg::SEL_ID)
            |=> (tdo_q == $past(id_q[0]));
    endproperty
    a_lsb_out: assert property (p_lsb_out) else $error("tdo not the lsb");

endmodule // sbt_tap

// ---- sim/sbt_jtag_host.sv ----
// behavioural boundary-scan controller that drives the test pins
`timescale 1ns/10ps
module sbt_jtag_host (
    input wire logic sys_clk,
    input wire logic tdo,
    input wire logic tdo_oe,
    output sbt_pkg::sbt_pins_s pins
);
    // no pull on data out, so a floating pin reads z
    wire logic tdo_pin = tdo_oe ? tdo : 1'bz;

    initial pins = sbt_pkg::PIN_RST_VAL;

    // one test clock period: low 50 ns, high 30 ns, inputs move just after the fall
    task automatic step(input logic t, input logic d, output logic o);
        @(posedge sys_clk);
        pins.tms <= t;
        pins.tdi <= d;
        repeat (4) @(posedge sys_clk);
        o = tdo_pin; // read late in the low phase, well after the fall
        pins.tck <= 1'b1;
        repeat (3) @(posedge sys_clk);
        pins.tck <= 1'b0;
    endtask

    // clock parked low while the other pins wander
    task automatic park(input logic [31:0] r);
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            pins.tms <= r[2*i];
            pins.tdi <= r[2*i+1];
        end
    endtask

    // five rises with mode select high reach reset from any state
    task automatic to_reset();
        logic o;
        for (int i = 0; i < 5; i++) begin
            step(1'b1, 1'b1, o);
        end
    endtask
endmodule // sbt_jtag_host

// ---- sim/tb_top.sv ----
// self-checking bench for the boundary-scan test access port
`timescale 1ns/10ps
module tb_top;
    logic sys_clk;
    logic rst;
    logic [sbt_pkg::BSR_W-1:0] ring_in;
    logic tdo;
    logic tdo_oe;
    logic out_hiz;
    logic [sbt_pkg::IR_W-1:0] instr;
    logic [sbt_pkg::BSR_W-1:0] bsr_update;
    sbt_pkg::sbt_pins_s pins;
    int n_fail;
    int n_compared;
    int cycles;
    integer seed;

    sbt_jtag_host host (.sys_clk(sys_clk), .tdo(tdo), .tdo_oe(tdo_oe), .pins(pins));

    sbt_tap dut (
        .sys_clk(sys_clk), .rst(rst), .tck(pins.tck), .tms(pins.tms), .tdi(pins.tdi),
        .ring_in(ring_in), .tdo(tdo), .tdo_oe(tdo_oe), .instr(instr),
        .bsr_update(bsr_update), .out_hiz(out_hiz)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic cmp_vec(input string what, input logic [127:0] e, input logic [127:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic cmp_bit(input string what, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %b seen %b", what, e, g);
        end
    endtask

    // idle to idle through one scan; data out must float around the shift
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout);
        logic o;
        dout = '0;
        host.step(1'b1, 1'b0, o);
        if (ir) host.step(1'b1, 1'b0, o);
        host.step(1'b0, 1'b0, o);
        host.step(1'b0, 1'b0, o);
        cmp_bit("tdo before shift", 1'bz, o);
        for (int i = 0; i < n; i++) begin
            host.step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        host.step(1'b1, 1'b0, o);
        cmp_bit("tdo after shift", 1'bz, o);
        host.step(1'b0, 1'b0, o);
        repeat (3) @(negedge sys_clk);
    endtask

    // what leaves data out: captured word first, then bits shifted in
    // only the 110 bits that one boundary-length scan can return
    function automatic logic [109:0] exp_dr(input logic [2:0] c, input logic [127:0] din,
                                            input logic [109:0] ring);
        case (c)
            sbt_pkg::INS_IDCODE: return {din[77:0], sbt_pkg::IDCODE_VAL};
            sbt_pkg::INS_EXTEST, sbt_pkg::INS_SAMPLEZ, sbt_pkg::INS_PRELOAD:
                return ring;
            default: return {din[108:0], 1'h0};
        endcase
    endfunction

    function automatic logic [127:0] rnd128();
        return {$random(seed), $random(seed), $random(seed), $random(seed)};
    endfunction

    // hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_fail++;
            $display("BAD run length expected 60000 seen more");
            wrap_up();
        end
    end

    initial begin
        logic [127:0] din;
        logic [127:0] dout;
        logic [109:0] upd;
        logic [2:0] c;
        logic o;
        seed = 32'hAF50;
        n_fail = 0;
        n_compared = 0;
        cycles = 0;
        rst = 1'b1;
        ring_in = '0;
        upd = '0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        cmp_vec("instr at reset", sbt_pkg::INS_IDCODE, instr);
        cmp_bit("out_hiz at reset", 1'b0, out_hiz);
        host.park($random(seed));
        @(negedge sys_clk);
        cmp_bit("tdo_oe parked", 1'b0, tdo_oe);
        host.step(1'b0, 1'b0, o);
        din = rnd128();
        scan(1'b0, 32, din, dout);
        cmp_vec("id word", sbt_pkg::IDCODE_VAL, dout[31:0]);
        // every code once in order, then random ones
        for (int k = 0; k < 16; k++) begin
            c = (k < 8) ? 3'(k) : 3'($random(seed));
            scan(1'b1, 3, {125'h0, c}, dout);
            cmp_vec("ir capture", 3'h1, dout[2:0]);
            cmp_vec("instr", c, instr);
            // ring moves on a rising edge, well before the capture
            @(posedge sys_clk);
            din = rnd128();
            ring_in <= din[109:0];
            din = rnd128();
            scan(1'b0, 110, din, dout);
            cmp_vec("dr out", exp_dr(c, din, ring_in), dout[109:0]);
            if (c == 3'h0 || c == 3'h2 || c == 3'h4) upd = din[109:0];
            cmp_vec("bsr_update", upd, bsr_update);
            cmp_bit("out_hiz", c == 3'h2 || (c == 3'h0 && !upd[109]), out_hiz);
        end
        // leave shift-DR after four shifted bits by five high rises
        scan(1'b1, 3, 128'h0, dout);
        for (int i = 0; i < 6; i++) host.step(i < 1, 1'b1, o);
        host.to_reset();
        repeat (4) @(negedge sys_clk);
        cmp_vec("instr after tms reset", sbt_pkg::INS_IDCODE, instr);
        cmp_vec("bsr_update after tms reset", 110'h0, bsr_update);
        cmp_bit("out_hiz after tms reset", 1'b0, out_hiz);
        // second power-up reset after a bypass load
        host.step(1'b0, 1'b0, o);
        scan(1'b1, 3, 128'h7, dout);
        cmp_vec("instr before rst", sbt_pkg::INS_BYPASS, instr);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        cmp_vec("instr after rst", sbt_pkg::INS_IDCODE, instr);
        cmp_bit("tdo_oe after rst", 1'b0, tdo_oe);
        wrap_up();
    end
endmodule // tb_top
